/* logic/shm_host_map.v */
`include "shm_map.vh"

module shm_host_map #(
  parameter NODES = 64,
  parameter MSG_DEPTH = 128
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // host parallel bus
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [8:0] host_address_bits,
  input wire short_win,
  input wire [15:0] dq_i,
  output wire [15:0] dq_o,
  output wire dq_oe,
  // static straps
  input wire clk_sel,
  input wire [1:0] spd_sel,
  // serial line
  input wire sia,
  output wire so,
  output wire so_en,
  output reg cycle_mark
);

  // ****************************************
  // states and indices
  // ****************************************
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_SEND = 7'h02;
  localparam [6:0] ST_WAIT = 7'h04;
  localparam [6:0] ST_RECV = 7'h08;
  localparam [6:0] ST_UPD = 7'h10;
  localparam [6:0] ST_FLAG = 7'h20;
  localparam [6:0] ST_MSG = 7'h40;
  localparam [8:0] ERR_B = `SHM_ERR_OFF;
  localparam [8:0] IEN_B = `SHM_IEN_OFF;
  localparam [8:0] CHG_B = `SHM_CHG_OFF;
  localparam [8:0] IMG_B = `SHM_IMG_OFF;
  localparam integer LAST_NODE_I = NODES - 1; // full width, cut below on purpose
  localparam [5:0] LAST_NODE = LAST_NODE_I[5:0];

  // ****************************************
  // pin synchronisers, two stages each
  // ****************************************
  reg [32:0] s1_q; // first stage, read only by s2_q
  reg [32:0] s2_q; // second stage, used by logic
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s1_q <= {33{1'b1}};
      s2_q <= {33{1'b1}};
    end else begin
      s1_q <= {short_win, cs_n, rd_n, wr_n, sia, clk_sel, spd_sel, host_address_bits, dq_i};
      s2_q <= s1_q;
    end
  end
  wire short_s = s2_q[32];
  wire cs_s = ~s2_q[31];
  wire rd_s = ~s2_q[30];
  wire wr_s = ~s2_q[29];
  wire sia_s = s2_q[28];
  wire clk_sel_s = s2_q[27];
  wire [1:0] spd_s = s2_q[26:25];
  wire [15:0] dat_s = s2_q[15:0];
  // short mode keeps only the low three bits
  wire [8:0] adr_s = short_s ? {6'h00, s2_q[18:16]} : s2_q[24:16];

  // ****************************************
  // storage and control registers
  // ****************************************
  reg [15:0] mem_q [0:255]; // info, flags, enables, port image
  reg [15:0] msg_q [0:MSG_DEPTH-1]; // outgoing message words
  reg [7:0] msg_cnt_q; // words queued
  reg [5:0] msg_node_q; // message target
  reg msg_pend_q; // message waiting for a slot
  reg [15:0] ibuf_q; // indirect access buffer
  reg [15:0] cause_q; // sticky event summary
  reg [15:0] rdata_q; // registered read data
  reg run_q; // polling enabled
  reg wr_prev_q; // write strobe history
  reg rd_prev_q; // read strobe history
  reg ind_wr_q; // indirect write pending
  reg [8:0] ind_adr_q; // indirect target address
  reg [6:0] st_q; // poll state
  reg [5:0] node_q; // node being polled
  reg [5:0] wait_q; // response wait in bit times
  reg [3:0] rbit_q; // received bit count
  reg [7:0] rx_q; // received port byte
  reg [7:0] mix_q; // message word index
  reg err_q; // current node gave no answer
  reg chg_q; // current node input changed
  reg tx_start;
  reg [15:0] tx_word;
  wire tx_busy;
  wire tick;
  integer i;

  // ****************************************
  // read decode, shared by bus and indirect path
  // ****************************************
  function [15:0] read_word;
    input [8:0] a;
    begin
      case (a)
        `SHM_CMD_OFF: read_word = {13'h0000, cycle_mark, msg_pend_q, run_q}; // main status
        `SHM_CAUSE_OFF: read_word = cause_q;
        `SHM_IBUF_OFF: read_word = ibuf_q;
        `SHM_MSGQ_OFF: read_word = {8'h00, msg_cnt_q};
        default: read_word = (a >= `SHM_INFO_OFF) ? mem_q[a[8:1]] : `SHM_WORD_RST;
      endcase
    end
  endfunction

  // ****************************************
  // host strobes
  // ****************************************
  wire wr_act = cs_s & wr_s;
  wire rd_act = cs_s & rd_s;
  // data taken at the end of the write strobe, when it is surely stable
  wire wr_fire = wr_prev_q & ~wr_act;
  // read side effects wait for the strobe end, so the host sees the old value
  wire rd_end = rd_prev_q & ~rd_act;
  wire [3:0] op = dat_s[`SHM_OP_MSB:`SHM_OP_LSB];
  wire cmd_fire = wr_fire && adr_s == `SHM_CMD_OFF;
  // one array write per cycle: host first, then indirect, then poll engine
  wire mw_host = wr_fire && adr_s >= `SHM_INFO_OFF;
  wire mw_ind = ind_wr_q && !mw_host && ind_adr_q >= `SHM_INFO_OFF;
  wire hw_free = !mw_host && !ind_wr_q;
  wire [8:0] mw_a = mw_host ? adr_s : ind_adr_q;
  wire [15:0] mw_d = mw_host ? dat_s : ibuf_q;
  // write-one-to-clear ranges
  wire mw_w1c = (mw_a >= ERR_B && mw_a < IEN_B) || (mw_a >= CHG_B && mw_a < IMG_B);

  // per node indices: each node owns four ports, port 2 is read back
  wire [7:0] img_w = IMG_B[8:1] + {1'b0, node_q, 1'b1};
  wire [7:0] err_w = ERR_B[8:1] + {6'h00, node_q[5:4]};
  wire [7:0] chg_w = CHG_B[8:1] + {4'h0, node_q[5:2]};
  wire [7:0] ien_w = IEN_B[8:1] + {4'h0, node_q[5:2]};
  wire [3:0] pbit = {node_q[1:0], 2'b10};
  wire [15:0] ien_word = mem_q[ien_w];

  assign dq_o = rdata_q;
  assign dq_oe = rd_act;

  // ****************************************
  // line transmitter and rate divider
  // ****************************************
  shm_line_tx u_tx (
    .clk(clk),
    .arst_n(arst_n),
    .clk_sel(clk_sel_s),
    .spd_sel(spd_s),
    .start(tx_start),
    .word(tx_word),
    .so(so),
    .so_en(so_en),
    .busy(tx_busy),
    .bit_tick(tick)
  );

  // ****************************************
  // transmit word select
  // ****************************************
  always @* begin
    tx_start = 1'b0;
    tx_word = `SHM_WORD_RST;
    case (st_q)
      ST_SEND: begin
        // address word carries node and its output port 0 byte
        tx_start = 1'b1;
        tx_word = {2'b00, node_q, mem_q[img_w - 8'h01][7:0]};
      end
      ST_MSG: begin
        // header first, then queued words
        tx_start = !tx_busy;
        tx_word = (mix_q == 8'h00) ? {2'b11, msg_node_q, msg_cnt_q} : msg_q[mix_q[6:0] - 7'h01];
      end
      default: begin
        tx_start = 1'b0;
      end
    endcase
  end

  // ****************************************
  // host side registers and storage
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < 256; i = i + 1) begin
        mem_q[i] <= `SHM_WORD_RST;
      end
      for (i = 0; i < MSG_DEPTH; i = i + 1) begin
        msg_q[i] <= `SHM_WORD_RST;
      end
      msg_cnt_q <= 8'h00;
      msg_node_q <= 6'h00;
      ibuf_q <= `SHM_WORD_RST;
      cause_q <= `SHM_WORD_RST;
      rdata_q <= `SHM_WORD_RST;
      run_q <= 1'b0;
      wr_prev_q <= 1'b0;
      rd_prev_q <= 1'b0;
      ind_wr_q <= 1'b0;
      ind_adr_q <= 9'h000;
    end else begin
      wr_prev_q <= wr_act;
      rd_prev_q <= rd_act;
      rdata_q <= read_word(adr_s);
      // indirect write runs one cycle after its command, later if the host writes
      if (mw_ind || (ind_wr_q && hw_free) || (ind_wr_q && !mw_host)) begin
        ind_wr_q <= 1'b0;
        if (ind_adr_q == `SHM_IBUF_OFF) begin
          ibuf_q <= ibuf_q;
        end
      end
      // array write: info, enables, image plain; flags clear on ones
      if (mw_host || mw_ind) begin
        if (mw_w1c) begin
          mem_q[mw_a[8:1]] <= mem_q[mw_a[8:1]] & ~mw_d;
        end else begin
          mem_q[mw_a[8:1]] <= mw_d;
        end
      end else if (st_q == ST_UPD && err_q) begin
        mem_q[err_w] <= mem_q[err_w] | (16'h0001 << node_q[3:0]);
      end else if (st_q == ST_UPD) begin
        mem_q[img_w] <= {mem_q[img_w][15:8], rx_q};
      end else if (st_q == ST_FLAG && chg_q) begin
        mem_q[chg_w] <= mem_q[chg_w] | (16'h0001 << pbit);
      end
      if (wr_fire && adr_s == `SHM_IBUF_OFF) begin
        ibuf_q <= dat_s;
      end
      // message queue fill, refused when full
      if (wr_fire && adr_s == `SHM_MSGQ_OFF && msg_cnt_q < `SHM_MSG_MAX && !msg_pend_q) begin
        msg_q[msg_cnt_q[6:0]] <= dat_s;
        msg_cnt_q <= msg_cnt_q + 8'h01;
      end else if (st_q == ST_MSG && mix_q == msg_cnt_q && tx_start) begin
        msg_cnt_q <= 8'h00;
      end
      // operation commands; writes to the cause word fall through unused
      if (cmd_fire) begin
        case (op)
          `SHM_OP_START: run_q <= 1'b1;
          `SHM_OP_STOP: run_q <= 1'b0;
          `SHM_OP_IND_RD: ibuf_q <= read_word(dat_s[8:0]);
          `SHM_OP_IND_WR: begin
            ind_wr_q <= 1'b1;
            ind_adr_q <= dat_s[8:0];
          end
          `SHM_OP_SEND_MSG: msg_node_q <= dat_s[5:0];
          `SHM_OP_CLR_MSG: begin
            if (!msg_pend_q) begin
              msg_cnt_q <= 8'h00;
            end
          end
          default: run_q <= run_q;
        endcase
      end
      // sticky cause bits, cleared as a read of them ends; a new event wins
      if (rd_end && adr_s == `SHM_CAUSE_OFF) begin
        cause_q <= `SHM_WORD_RST;
      end
      if (st_q == ST_UPD && err_q) begin
        cause_q[`SHM_CS_ERR] <= 1'b1;
      end
      if (st_q == ST_FLAG && chg_q) begin
        cause_q[`SHM_CS_CHG] <= 1'b1;
      end
      if (st_q == ST_FLAG && node_q == LAST_NODE) begin
        cause_q[`SHM_CS_CYC] <= 1'b1;
      end
    end
  end

  // ****************************************
  // cyclic poll engine
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= ST_IDLE;
      node_q <= 6'h00;
      wait_q <= 6'h00;
      rbit_q <= 4'h0;
      rx_q <= 8'h00;
      mix_q <= 8'h00;
      err_q <= 1'b0;
      chg_q <= 1'b0;
      msg_pend_q <= 1'b0;
      cycle_mark <= 1'b0;
    end else begin
      // a message is only armed with at least one word
      if (cmd_fire && op == `SHM_OP_SEND_MSG && msg_cnt_q != 8'h00) begin
        msg_pend_q <= 1'b1;
      end
      case (st_q)
        ST_IDLE: begin
          node_q <= 6'h00;
          if (run_q) begin
            st_q <= ST_SEND;
          end
        end
        ST_SEND: begin
          // hold until the line takes the word; a message tail may still be out
          if (!tx_busy) begin
            st_q <= ST_WAIT;
            wait_q <= 6'h00;
          end
        end
        ST_WAIT: begin
          // same timeout per node whatever its kind; a start bit on sia ends the wait early
          if (!tx_busy && tick) begin
            if (!sia_s) begin
              st_q <= ST_RECV;
              rbit_q <= 4'h0;
            end else if (wait_q == `SHM_RESP_WAIT) begin
              err_q <= 1'b1;
              st_q <= ST_UPD;
            end else begin
              wait_q <= wait_q + 6'h01;
            end
          end
        end
        ST_RECV: begin
          if (tick) begin
            rx_q <= {sia_s, rx_q[7:1]};
            rbit_q <= rbit_q + 4'h1;
            if (rbit_q == 4'h7) begin
              err_q <= 1'b0;
              st_q <= ST_UPD;
            end
          end
        end
        ST_UPD: begin
          // waits while a host write owns the array
          if (hw_free) begin
            chg_q <= !err_q && (mem_q[img_w][7:0] != rx_q) && ien_word[pbit];
            st_q <= ST_FLAG;
          end
        end
        ST_FLAG: begin
          if (hw_free) begin
            err_q <= 1'b0;
            chg_q <= 1'b0;
            node_q <= (node_q == LAST_NODE) ? 6'h00 : node_q + 6'h01;
            if (node_q == LAST_NODE) begin
              cycle_mark <= ~cycle_mark;
            end
            // transient message slips in between node slots
            if (msg_pend_q) begin
              st_q <= ST_MSG;
              mix_q <= 8'h00;
            end else begin
              st_q <= run_q ? ST_SEND : ST_IDLE;
            end
          end
        end
        ST_MSG: begin
          if (tx_start) begin
            mix_q <= mix_q + 8'h01;
            if (mix_q == msg_cnt_q) begin
              msg_pend_q <= 1'b0;
              st_q <= run_q ? ST_SEND : ST_IDLE;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

endmodule

/* logic/shm_map.vh */
`ifndef SHM_MAP_VH
`define SHM_MAP_VH

// ****************************************
// host address map (byte offsets)
// ****************************************
`define SHM_CMD_OFF 9'h000
`define SHM_CAUSE_OFF 9'h002
`define SHM_IBUF_OFF 9'h004
`define SHM_MSGQ_OFF 9'h006
`define SHM_INFO_OFF 9'h078
`define SHM_ERR_OFF 9'h0b8
`define SHM_IEN_OFF 9'h0c0
`define SHM_CHG_OFF 9'h0e0
`define SHM_IMG_OFF 9'h100

// ****************************************
// command word fields
// ****************************************
`define SHM_OP_MSB 15
`define SHM_OP_LSB 12
`define SHM_OP_START 4'h1
`define SHM_OP_STOP 4'h2
`define SHM_OP_IND_RD 4'h3
`define SHM_OP_IND_WR 4'h4
`define SHM_OP_SEND_MSG 4'h5
`define SHM_OP_CLR_MSG 4'h6

// ****************************************
// main status and cause bit positions
// ****************************************
`define SHM_ST_RUN 0
`define SHM_ST_MSG 1
`define SHM_ST_CYC 2
`define SHM_CS_ERR 0
`define SHM_CS_CHG 1
`define SHM_CS_CYC 2

// ****************************************
// reset values
// ****************************************
`define SHM_WORD_RST 16'h0000

// ****************************************
// timing counts (reference clock cycles / bit times) and message queue limit (words)
// ****************************************
`define SHM_DIV_40 6'h02
`define SHM_DIV_80 6'h04
`define SHM_FRAME_BITS 5'h12
`define SHM_RESP_WAIT 6'h20
`define SHM_MSG_MAX 8'h80

`endif

/* logic/shm_line_tx.v */
// ****************************************
// line rate divider and nrz serializer
// ****************************************
module shm_line_tx (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // static selections, already synchronised
  input wire clk_sel,
  input wire [1:0] spd_sel,
  // word to send
  input wire start,
  input wire [15:0] word,
  // line side
  output reg so,
  output reg so_en,
  output wire busy,
  output wire bit_tick
);

  reg [5:0] div_q; // cycles left in current bit
  reg [4:0] bits_q; // bits left in frame
  reg [17:0] sh_q; // stop, data lsb first, start
  wire [5:0] base;
  wire [5:0] period;

  // same top rate for either reference clock
  assign base = clk_sel ? `SHM_DIV_80 : `SHM_DIV_40;
  // lower rates are plain multiples of one clock
  assign period = base << spd_sel;
  assign bit_tick = (div_q == 6'h00);
  assign busy = (bits_q != 5'h00);

  // ****************************************
  // bit timer and shifter
  // ****************************************
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_q <= 6'h00;
      bits_q <= 5'h00;
      sh_q <= 18'h3ffff;
      so <= 1'b1;
      so_en <= 1'b0;
    end else begin
      // free running so receiver shares the tick
      div_q <= bit_tick ? period - 6'h01 : div_q - 6'h01;
      if (start && !busy) begin
        sh_q <= {1'b1, word, 1'b0};
        bits_q <= `SHM_FRAME_BITS;
      end else if (bit_tick && busy) begin
        // nrz: level held for the whole bit
        so <= sh_q[0];
        so_en <= 1'b1;
        sh_q <= {1'b1, sh_q[17:1]};
        bits_q <= bits_q - 5'h01;
      end else if (bit_tick) begin
        // driver released once the stop bit ends
        so <= 1'b1;
        so_en <= 1'b0;
      end
    end
  end

endmodule

/* tb/shm_host_map_sva.sv */
// ****************************************
// port checker for the host map block
// ****************************************
module shm_host_map_sva #(
  parameter NODES = 64,
  parameter MSG_DEPTH = 128
) (
  // clock and reset
  input wire clk,
  input wire arst_n,
  // host bus
  input wire cs_n,
  input wire rd_n,
  input wire wr_n,
  input wire [8:0] host_address_bits,
  input wire short_win,
  input wire [15:0] dq_i,
  input wire [15:0] dq_o,
  input wire dq_oe,
  // straps
  input wire clk_sel,
  input wire [1:0] spd_sel,
  // serial line
  input wire sia,
  input wire so,
  input wire so_en,
  input wire cycle_mark
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // clocks per bit; both straps must give the same top rate
  logic [9:0] div;
  // clocks seen since the driver turned on
  logic [9:0] cnt_q;
  logic [9:0] cnt_d;
  assign div = (clk_sel ? 10'h004 : 10'h002) << spd_sel;
  assign cnt_d = so_en ? cnt_q + 10'h001 : 10'h000;
  // frame cycle counter, cleared whenever the line is released
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 10'h000;
    end else begin
      cnt_q <= cnt_d;
    end
  end
  // ****************************************
  // sequences and properties
  // ****************************************
  sequence s_read_held;
    (!cs_n && !rd_n) [*4];
  endsequence
  sequence s_frame_open;
    (so_en && !so) [*2];
  endsequence
  property p_oe_on_read;
    s_read_held |-> dq_oe;
  endproperty
  property p_oe_needs_read;
    dq_oe |-> (!$past(cs_n, 2) && !$past(rd_n, 2)) || (!$past(cs_n, 3) && !$past(rd_n, 3));
  endproperty
  property p_oe_release;
    $rose(cs_n) |-> ##[1:3] !dq_oe;
  endproperty
  property p_write_quiet;
    (!cs_n && !wr_n && rd_n) [*4] |-> !dq_oe;
  endproperty
  property p_idle_high;
    !so_en |-> so;
  endproperty
  property p_start_bit;
    $rose(so_en) |-> s_frame_open;
  endproperty
  property p_bit_edges;
    ($changed(so) && so_en && $past(so_en)) |-> (cnt_q % div == 10'h000);
  endproperty
  property p_frame_len;
    $fell(so_en) |-> (cnt_q != 10'h000) && (cnt_q % (10'h012 * div) == 10'h000);
  endproperty
  property p_mark_spacing;
    $changed(cycle_mark) |=> $stable(cycle_mark) [*8];
  endproperty
  a_oe_on_read: assert property (p_oe_on_read) else $error("bus not driven during read");
  a_oe_needs_read: assert property (p_oe_needs_read) else $error("bus driven without read");
  a_oe_release: assert property (p_oe_release) else $error("bus held after deselect");
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven during write");
  a_idle_high: assert property (p_idle_high) else $error("line low while released");
  a_start_bit: assert property (p_start_bit) else $error("frame lacks start bit");
  a_bit_edges: assert property (p_bit_edges) else $error("bit edge off divisor");
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
  a_mark_spacing: assert property (p_mark_spacing) else $error("pass marker too fast");
endmodule

bind shm_host_map shm_host_map_sva #(.NODES(NODES), .MSG_DEPTH(MSG_DEPTH)) u_sva (
  .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
  .host_address_bits(host_address_bits), .short_win(short_win), .dq_i(dq_i),
  .dq_o(dq_o), .dq_oe(dq_oe), .clk_sel(clk_sel), .spd_sel(spd_sel), .sia(sia),
  .so(so), .so_en(so_en), .cycle_mark(cycle_mark)
);

/* tb/shm_node_model.sv */
// ****************************************
// remote node on the far end of the line
// ****************************************
module shm_node_model (
  // clock
  input wire clk,
  // line from the block
  input wire so,
  input wire so_en,
  // bench settings
  input wire [9:0] div,
  input wire [7:0] reply_byte,
  // line back and captured word
  output logic sia,
  output logic [15:0] last_word
);
  timeunit 1ns;
  timeprecision 1ns;
  // decode mid-bit the first frame after so_en rises, then answer once the line is free
  initial begin
    sia = 1'b1;
    last_word = 16'h0000;
    forever begin
      @(posedge so_en);
      repeat (div / 2) @(posedge clk);
      for (int i = 0; i < 16; i++) begin
        repeat (div) @(posedge clk);
        #1;
        last_word[i] = so;
      end
      @(negedge so_en);
      // only node 0 answers; talking over the block would corrupt both
      if (last_word[15:8] == 8'h00) begin
        repeat (div * 4) @(posedge clk);
        sia <= 1'b0;
        for (int i = 0; i < 8; i++) begin
          repeat (div) @(posedge clk);
          sia <= reply_byte[i];
        end
        repeat (div) @(posedge clk);
        sia <= 1'b1;
      end
    end
  end
endmodule

/* tb/shm_host_map_tb.sv */
module shm_host_map_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic cs_n = 1'b1, rd_n = 1'b1, wr_n = 1'b1;
  logic [8:0] addr = 9'h000;
  logic short_win = 1'b0;
  logic [15:0] dq_i = 16'h0000;
  logic clk_sel = 1'b0;
  logic [1:0] spd_sel = 2'h0;
  logic [9:0] div = 10'h002;
  wire [15:0] dq_o, last_word;
  wire dq_oe, so, so_en, cycle_mark, sia;
  int failures = 0, total_checks = 0, cycles = 0;

  shm_host_map #(.NODES(64), .MSG_DEPTH(128)) DUT (
    .clk(clk), .arst_n(arst_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .host_address_bits(addr), .short_win(short_win), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe(dq_oe), .clk_sel(clk_sel), .spd_sel(spd_sel), .sia(sia), .so(so),
    .so_en(so_en), .cycle_mark(cycle_mark));
  shm_node_model u_node (.clk(clk), .so(so), .so_en(so_en), .div(div),
    .reply_byte(8'h5a), .sia(sia), .last_word(last_word));

  // 10 MHz reference
  initial forever #50 clk = ~clk;
  // hang guard, well above the longest expected run
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      failures++;
      summarize();
    end
  end
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string m);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %0t %s seen %h exp %h", $time, m, seen, exp);
    end
  endtask
  // strobes held five clocks, address kept past the synchroniser
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    @(posedge clk);
    cs_n <= 1'b0;
    wr_n <= 1'b0;
    addr <= a;
    dq_i <= d;
    cyc(5);
    cs_n <= 1'b1;
    wr_n <= 1'b1;
    cyc(5);
  endtask
  task automatic rd(input logic [8:0] a, input logic [15:0] exp, input string m);
    @(posedge clk);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    addr <= a;
    cyc(6);
    #1;
    chk(dq_o, exp, m);
    @(posedge clk);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    cyc(5);
  endtask
  task automatic cmd(input logic [3:0] op, input logic [8:0] arg);
    wr(9'h000, {op, 3'h0, arg});
  endtask
  // bounded wait for the line driver to reach a level
  task automatic line_to(input logic lvl);
    int n;
    n = 0;
    while (so_en !== lvl && n < 5000) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(so_en, lvl, "line wait");
  endtask
  task automatic do_reset();
    arst_n <= 1'b0;
    cyc(3);
    arst_n <= 1'b1;
    cyc(2);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_map();
    logic [8:0] at [6];
    at = '{9'h078, 9'h0b6, 9'h0c0, 9'h0de, 9'h100, 9'h1fe};
    chk({so, so_en, dq_oe, cycle_mark}, 16'h0008, "idle pins");
    foreach (at[i]) wr(at[i], {7'h29, at[i]});
    foreach (at[i]) rd(at[i], {7'h29, at[i]}, "rw word");
    wr(9'h010, 16'hffff);
    rd(9'h010, 16'h0000, "unmapped");
    wr(9'h002, 16'hffff);
    rd(9'h002, 16'h0000, "cause write");
    $display("test map done");
  endtask
  task automatic t_short();
    short_win <= 1'b1;
    wr(9'h1fc, 16'ha55a);
    rd(9'h0fc, 16'ha55a, "short alias");
    cmd(4'h4, 9'h07a);
    short_win <= 1'b0;
    rd(9'h07a, 16'ha55a, "ind write");
    wr(9'h0c2, 16'h1234);
    short_win <= 1'b1;
    cmd(4'h3, 9'h0c2);
    rd(9'h004, 16'h1234, "ind read");
    short_win <= 1'b0;
    $display("test short done");
  endtask
  task automatic t_msg();
    int n;
    rd(9'h006, 16'h0000, "queue empty");
    wr(9'h006, 16'hbeef);
    rd(9'h006, 16'h0001, "queue one");
    cmd(4'h6, 9'h000);
    rd(9'h006, 16'h0000, "queue cleared");
    cmd(4'h5, 9'h000);
    rd(9'h000, 16'h0000, "empty send");
    wr(9'h006, 16'h1111);
    wr(9'h006, 16'h2222);
    cmd(4'h1, 9'h000);
    cmd(4'h5, 9'h005);
    rd(9'h000, 16'h0003, "msg pending");
    n = 0;
    while (last_word !== 16'hc502 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    chk(last_word, 16'hc502, "msg header");
    cmd(4'h2, 9'h000);
    cyc(300);
    rd(9'h006, 16'h0000, "queue sent");
    rd(9'h000, 16'h0000, "msg done");
    $display("test msg done");
  endtask
  task automatic t_poll();
    logic m;
    int n;
    wr(9'h0c0, 16'h0004);
    wr(9'h100, 16'h003c);
    wr(9'h102, 16'h0000);
    cmd(4'h1, 9'h000);
    line_to(1'b1);
    line_to(1'b0);
    chk(last_word, 16'h003c, "poll word");
    m = cycle_mark;
    n = 0;
    while (cycle_mark === m && n < 20000) begin
      @(posedge clk);
      n++;
    end
    chk(cycle_mark, {15'h0000, ~m}, "pass end");
    rd(9'h000, 16'h0005, "running");
    cmd(4'h2, 9'h000);
    cyc(3000);
    rd(9'h000, 16'h0004, "stopped");
    rd(9'h102, 16'h005a, "reply image");
    rd(9'h0b8, 16'hfffe, "err low");
    rd(9'h0be, 16'hffff, "err high");
    wr(9'h0b8, 16'hffff);
    rd(9'h0b8, 16'h0000, "err cleared");
    rd(9'h0e0, 16'h0004, "change flag");
    wr(9'h0e0, 16'hffff);
    rd(9'h0e0, 16'h0000, "change cleared");
    rd(9'h002, 16'h0007, "cause");
    rd(9'h002, 16'h0000, "cause cleared");
    $display("test poll done");
  endtask
  task automatic t_rate();
    logic [2:0] cfg [4];
    int n;
    cfg = '{3'h0, 3'h4, 3'h3, 3'h6};
    foreach (cfg[i]) begin
      clk_sel <= cfg[i][2];
      spd_sel <= cfg[i][1:0];
      div <= (cfg[i][2] ? 10'h004 : 10'h002) << cfg[i][1:0];
      do_reset();
      cmd(4'h1, 9'h000);
      line_to(1'b1);
      n = 0;
      while (so_en === 1'b1 && n < 1000) begin
        @(posedge clk);
        #1;
        n++;
      end
      chk(n[15:0], 16'(div * 10'h012), "frame clocks");
      cmd(4'h2, 9'h000);
      cyc(120 * div);
    end
    $display("test rate done");
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    t_map();
    t_short();
    t_msg();
    t_poll();
    t_rate();
    summarize();
  end
endmodule
